// *** hw/psam_consts.svh ***
/*
  constants of the program space access mapper: register offsets,
  field positions, reset values and extra-cycle counts.
  assumes nothing; included by bare name wherever needed.
*/
`ifndef PSAM_CONSTS_SVH
`define PSAM_CONSTS_SVH

// register byte offsets on the apb slave
`define PSAM_OFF_TBL_PAGE 12'h000
`define PSAM_OFF_VIS_PAGE 12'h004
`define PSAM_OFF_CPU_CTRL 12'h008
`define PSAM_OFF_STATUS 12'h00C

// field positions
`define PSAM_CTRL_VIS_EN_BIT 2
`define PSAM_STAT_BUSY_BIT 0
`define PSAM_STAT_CFGWR_BIT 1
`define PSAM_STAT_REDIR_BIT 2
`define PSAM_STAT_CFGRD_BIT 3
`define PSAM_PAGE_REGION_BIT 7

// reset values
`define PSAM_RST_TBL_PAGE 8'h00
`define PSAM_RST_VIS_PAGE 8'h00
`define PSAM_RST_VIS_EN 1'b0

// extra instruction cycles of a visibility-window read
`define PSAM_EXTRA_MOVE 2'd1
`define PSAM_EXTRA_OTHER 2'd2
`define PSAM_EXTRA_RPT_EDGE 2'd2
`define PSAM_EXTRA_RPT_MID 2'd0

`endif

// *** hw/psam_pkg.sv ***
/*
  types of the program space access mapper.
  assumes nothing of its surroundings.
*/
package psam_pkg;

  // kind of access the core asks for
  typedef enum logic [2:0] {
    PSAM_OP_FETCH = 3'h0,
    PSAM_OP_DATA_RD = 3'h1,
    PSAM_OP_TBL_RD_LO = 3'h2,
    PSAM_OP_TBL_RD_HI = 3'h3,
    PSAM_OP_TBL_WR_LO = 3'h4,
    PSAM_OP_TBL_WR_HI = 3'h5
  } psam_op_t;

  // instruction class, steers window stretch
  typedef enum logic [1:0] {
    PSAM_CLS_MOVE = 2'h0,
    PSAM_CLS_DMOVE = 2'h1,
    PSAM_CLS_OTHER = 2'h2
  } psam_cls_t;

  // access sequencer, gray along idle-fetch-capture-stretch
  typedef enum logic [1:0] {
    PSAM_ST_IDLE = 2'b00,
    PSAM_ST_FETCH = 2'b01,
    PSAM_ST_CAPTURE = 2'b11,
    PSAM_ST_STRETCH = 2'b10
  } psam_state_t;

endpackage

// *** hw/psam_read_format.sv ***
/*
  steers a 24-bit program word onto the 16-bit data result.
  assumes a stable word; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none

module psam_read_format import psam_pkg::*; (
  input wire logic [23:0] word_i,
  input wire logic high_i,
  input wire logic byte_mode_i,
  input wire logic byte_sel_i,
  output logic [15:0] data_o
);

  // lane selection; the high lane has a phantom byte that is zero
  always_comb begin
    if (!high_i) begin
      if (!byte_mode_i) begin
        data_o = word_i[15:0]; // see RULE9
      end else if (byte_sel_i) begin
        data_o = {8'h00, word_i[15:8]}; // see RULE10
      end else begin
        data_o = {8'h00, word_i[7:0]}; // see RULE10
      end
    end else begin
      if (!byte_mode_i || !byte_sel_i) begin
        data_o = {8'h00, word_i[23:16]}; // see RULE11
      end else begin
        data_o = 16'h0000; // see RULE12
      end
    end
  end

endmodule // psam_read_format

`default_nettype wire

// *** hw/psam_top.sv ***
/*
  program space access mapper: table accesses and the read-only
  visibility window onto 24-bit program memory, plus instruction
  fetch addressing and an apb register slave.
  assumes flash returns a word one cycle after flash_rd_o, one clock,
  and a core that holds off while ready_o is low.
*/
// Notes on behaviour
// RULE1 - table address is page above effective address
// RULE2 - page top bit selects user or configuration
// RULE3 - window address: zero, page, low fifteen bits
// RULE4 - redirect only if address bit15 and enabled
// RULE5 - window page picks one of 256 pages
// RULE6 - window returns low sixteen bits of word
// RULE7 - fetch address advances two per word
// RULE8 - low ops hit low word, high upper byte
// RULE9 - word low read copies bits 15..0
// RULE10 - byte low read picks byte by select
// RULE11 - word high read, upper result byte zero
// RULE12 - byte high read zero when select set
// RULE13 - configuration: reads only, implemented places only
// RULE14 - table accesses need no word alignment
// RULE15 - window read adds at least one cycle; mid repeat the code adds none
// RULE16 - window redirection paused during table accesses
// RULE17 - outside repeat: moves one, others two
// RULE18 - repeat: edges two extra, else single cycle
// RULE19 - table writes fill latches, never the array
// RULE20 - fetch keeps bit23 and bit0 at zero
`timescale 1ns/1ps
`default_nettype none
`include "psam_consts.svh"

module psam_top import psam_pkg::*; #(
  parameter logic [23:0] CFG_IMPL_LO = 24'h80_0000, // implemented config
  parameter logic [23:0] CFG_IMPL_HI = 24'hFF_FFFF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // core request side
  input wire logic req_i,
  input wire psam_op_t op_i,
  input wire logic byte_mode_i,
  input wire logic [15:0] ea_i,
  input wire logic [15:0] wdata_i,
  input wire logic [21:0] pc_i,
  input wire psam_cls_t cls_i,
  input wire logic in_rpt_i,
  input wire logic rpt_edge_i,
  output logic ready_o,
  output logic done_o,
  output logic [15:0] rdata_o,
  output logic ram_path_o,
  output logic refused_o,
  // program flash side
  output logic [23:0] flash_addr_o,
  output logic flash_rd_o,
  input wire logic [23:0] flash_rdata_i,
  output logic latch_we_o,
  output logic latch_high_o,
  output logic latch_byte_o,
  output logic [15:0] latch_data_o
);

  //////////////////////////////////////////////////////////////////////
  // register file state
  logic [7:0] tbl_page_q; // table_page_reg
  logic [7:0] vis_page_q; // visibility_page_reg
  logic vis_en_q; // visibility_enable in cpu_control_reg
  logic cfg_wr_err_q; // sticky: refused config write
  logic cfg_rd_err_q; // sticky: unimplemented config read
  logic redir_q; // last data read went through the window
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic apb_fire; // access phase completing this edge
  logic apb_wr;
  logic apb_map; // address hits a register
  logic [31:0] rd_mux;

  // sequencer state
  psam_state_t state_q;
  psam_op_t op_q;
  logic byte_q;
  logic [15:0] ea_q;
  logic [1:0] cnt_q; // remaining stretch cycles
  logic done_q;
  logic ready_q;
  logic [15:0] rdata_q;
  logic ram_q;
  logic refused_q;
  logic [23:0] addr_q;
  logic rd_q;
  logic zero_rd_q; // read answered with zero, flash not touched
  logic tbl_act_q; // table access in flight
  logic lwe_q;
  logic lhigh_q;
  logic lbyte_q;
  logic [15:0] ldata_q;
  logic cfg_wr_set;
  logic cfg_rd_set;

  // decode of the incoming request
  logic take;
  logic is_tbl;
  logic is_wr;
  logic redirect;
  logic [23:0] tbl_addr;
  logic [23:0] vis_addr;
  logic [23:0] fetch_addr;
  logic cfg_hit;
  logic cfg_impl;
  logic [1:0] extra_d;
  logic [15:0] fmt_data;

  //////////////////////////////////////////////////////////////////////
  // apb decode; one wait state keeps pready a plain flop
  assign apb_fire = psel_i & penable_i & pready_q;
  assign apb_wr = apb_fire & pwrite_i & apb_map;
  assign apb_map = (paddr_i == `PSAM_OFF_TBL_PAGE) ||
                   (paddr_i == `PSAM_OFF_VIS_PAGE) ||
                   (paddr_i == `PSAM_OFF_CPU_CTRL) ||
                   (paddr_i == `PSAM_OFF_STATUS);

  // read mux, reserved bits read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr_i)
      `PSAM_OFF_TBL_PAGE: rd_mux[7:0] = tbl_page_q;
      `PSAM_OFF_VIS_PAGE: rd_mux[7:0] = vis_page_q;
      `PSAM_OFF_CPU_CTRL: rd_mux[`PSAM_CTRL_VIS_EN_BIT] = vis_en_q;
      `PSAM_OFF_STATUS: begin
        rd_mux[`PSAM_STAT_BUSY_BIT] = (state_q != PSAM_ST_IDLE);
        rd_mux[`PSAM_STAT_CFGWR_BIT] = cfg_wr_err_q;
        rd_mux[`PSAM_STAT_REDIR_BIT] = redir_q;
        rd_mux[`PSAM_STAT_CFGRD_BIT] = cfg_rd_err_q;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // apb handshake and answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel_i & penable_i & ~pready_q;
      if (psel_i & penable_i & ~pready_q) begin
        prdata_q <= pwrite_i ? 32'h0000_0000 : rd_mux;
        pslverr_q <= ~apb_map; // unmapped address answers with error
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // page registers and window enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tbl_page_q <= `PSAM_RST_TBL_PAGE;
      vis_page_q <= `PSAM_RST_VIS_PAGE;
      vis_en_q <= `PSAM_RST_VIS_EN;
    end else if (apb_wr) begin
      if (paddr_i == `PSAM_OFF_TBL_PAGE) begin
        tbl_page_q <= pwdata_i[7:0];
      end
      if (paddr_i == `PSAM_OFF_VIS_PAGE) begin
        vis_page_q <= pwdata_i[7:0]; // full 8 bits: 256 pages, see RULE5
      end
      if (paddr_i == `PSAM_OFF_CPU_CTRL) begin
        vis_en_q <= pwdata_i[`PSAM_CTRL_VIS_EN_BIT]; // see RULE4
      end
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_wr_err_q <= 1'b0;
      cfg_rd_err_q <= 1'b0;
    end else begin
      if (cfg_wr_set) begin
        cfg_wr_err_q <= 1'b1;
      end else if (apb_wr && paddr_i == `PSAM_OFF_STATUS &&
                   pwdata_i[`PSAM_STAT_CFGWR_BIT]) begin
        cfg_wr_err_q <= 1'b0;
      end
      if (cfg_rd_set) begin
        cfg_rd_err_q <= 1'b1;
      end else if (apb_wr && paddr_i == `PSAM_OFF_STATUS &&
                   pwdata_i[`PSAM_STAT_CFGRD_BIT]) begin
        cfg_rd_err_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // request decode
  assign take = req_i & ready_q;
  assign is_tbl = (op_i == PSAM_OP_TBL_RD_LO) || (op_i == PSAM_OP_TBL_RD_HI)
               || is_wr; // see RULE8
  assign is_wr = (op_i == PSAM_OP_TBL_WR_LO) || (op_i == PSAM_OP_TBL_WR_HI);
  // full byte address kept, bit 0 is the byte select: see RULE14
  assign tbl_addr = {tbl_page_q, ea_i}; // see RULE1
  assign vis_addr = {1'b0, vis_page_q, ea_i[14:0]}; // see RULE3
  assign fetch_addr = {1'b0, pc_i, 1'b0}; // see RULE7, see RULE20
  assign cfg_hit = tbl_page_q[`PSAM_PAGE_REGION_BIT]; // see RULE2
  assign cfg_impl = (tbl_addr >= CFG_IMPL_LO) && (tbl_addr <= CFG_IMPL_HI);
  // a table access in flight pauses the window
  assign redirect = ea_i[15] & vis_en_q & ~tbl_act_q; // see RULE4, RULE16
  assign cfg_wr_set = take & is_wr & cfg_hit; // see RULE13
  assign cfg_rd_set = take & is_tbl & ~is_wr & cfg_hit & ~cfg_impl;

  // stretch length of a window read
  always_comb begin
    if (in_rpt_i) begin
      extra_d = rpt_edge_i ? `PSAM_EXTRA_RPT_EDGE
                           : `PSAM_EXTRA_RPT_MID; // see RULE18
    end else if (cls_i == PSAM_CLS_OTHER) begin
      extra_d = `PSAM_EXTRA_OTHER; // see RULE17
    end else begin
      extra_d = `PSAM_EXTRA_MOVE; // see RULE15, see RULE17
    end
  end

  // lane steering of the captured word
  psam_read_format u_fmt (
    .word_i(flash_rdata_i),
    .high_i(op_q == PSAM_OP_TBL_RD_HI),
    .byte_mode_i(byte_q),
    .byte_sel_i(ea_q[0]),
    .data_o(fmt_data)
  );

  //////////////////////////////////////////////////////////////////////
  // access sequencer: idle, fetch, capture, optional stretch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= PSAM_ST_IDLE;
      op_q <= PSAM_OP_FETCH;
      byte_q <= 1'b0;
      ea_q <= 16'h0000;
      cnt_q <= 2'd0;
      ready_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= 16'h0000;
      ram_q <= 1'b0;
      refused_q <= 1'b0;
      addr_q <= 24'h00_0000;
      rd_q <= 1'b0;
      zero_rd_q <= 1'b0;
      tbl_act_q <= 1'b0;
      redir_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      rd_q <= 1'b0;
      case (state_q)
        PSAM_ST_IDLE: begin
          ready_q <= 1'b1;
          if (take) begin
            ready_q <= 1'b0;
            op_q <= op_i;
            byte_q <= byte_mode_i & is_tbl; // window keeps word, see RULE6
            ea_q <= ea_i;
            ram_q <= 1'b0;
            refused_q <= 1'b0;
            zero_rd_q <= 1'b0;
            cnt_q <= 2'd0;
            tbl_act_q <= is_tbl;
            state_q <= PSAM_ST_FETCH;
            if (op_i == PSAM_OP_FETCH) begin
              addr_q <= fetch_addr;
              rd_q <= 1'b1;
            end else if (op_i == PSAM_OP_DATA_RD) begin
              redir_q <= redirect;
              if (redirect) begin
                addr_q <= vis_addr;
                rd_q <= 1'b1;
                cnt_q <= extra_d;
              end else begin
                ram_q <= 1'b1; // plain data space, ram answers
                done_q <= 1'b1;
                ready_q <= 1'b1;
                state_q <= PSAM_ST_IDLE;
              end
            end else begin
              addr_q <= tbl_addr;
              if (is_wr) begin
                refused_q <= cfg_hit; // see RULE13
              end else if (cfg_hit && !cfg_impl) begin
                zero_rd_q <= 1'b1; // see RULE13
                refused_q <= 1'b1;
              end else begin
                rd_q <= 1'b1;
              end
            end
          end
        end
        PSAM_ST_FETCH: begin
          state_q <= PSAM_ST_CAPTURE;
        end
        PSAM_ST_CAPTURE: begin
          // flash word valid now, one cycle after the read strobe
          if (zero_rd_q || (op_q == PSAM_OP_TBL_WR_LO) ||
              (op_q == PSAM_OP_TBL_WR_HI)) begin
            rdata_q <= 16'h0000;
          end else begin
            rdata_q <= fmt_data; // see RULE6
          end
          if (cnt_q == 2'd0) begin
            done_q <= 1'b1;
            ready_q <= 1'b1;
            tbl_act_q <= 1'b0;
            state_q <= PSAM_ST_IDLE;
          end else begin
            state_q <= PSAM_ST_STRETCH;
          end
        end
        PSAM_ST_STRETCH: begin
          // window read holds the instruction for its extra cycles
          if (cnt_q == 2'd1) begin
            done_q <= 1'b1;
            ready_q <= 1'b1;
            state_q <= PSAM_ST_IDLE;
          end
          cnt_q <= cnt_q - 2'd1;
        end
        default: begin
          state_q <= PSAM_ST_IDLE;
          ready_q <= 1'b0;
        end
      endcase
    end
  end

  // holding latch load; the array itself is never written here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lwe_q <= 1'b0;
      lhigh_q <= 1'b0;
      lbyte_q <= 1'b0;
      ldata_q <= 16'h0000;
    end else begin
      lwe_q <= take & is_wr & ~cfg_hit; // see RULE19, see RULE13
      if (take && is_wr) begin
        lhigh_q <= (op_i == PSAM_OP_TBL_WR_HI);
        lbyte_q <= byte_mode_i;
        ldata_q <= wdata_i;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign ready_o = ready_q;
  assign done_o = done_q;
  assign rdata_o = rdata_q;
  assign ram_path_o = ram_q;
  assign refused_o = refused_q;
  assign flash_addr_o = addr_q;
  assign flash_rd_o = rd_q;
  assign latch_we_o = lwe_q;
  assign latch_high_o = lhigh_q;
  assign latch_byte_o = lbyte_q;
  assign latch_data_o = ldata_q;

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_tbl_addr_form: assert property ( // see RULE1
    take && is_tbl && !is_wr && !(cfg_hit && !cfg_impl)
    |=> flash_rd_o && flash_addr_o == {$past(tbl_page_q), $past(ea_i)})
    else $error("table address not page over effective address");

  a_cfg_region: assert property ( // see RULE2
    take && is_tbl && !is_wr && cfg_impl && cfg_hit
    |=> flash_addr_o[23])
    else $error("config page did not reach config region");

  a_window_addr: assert property ( // see RULE3
    take && op_i == PSAM_OP_DATA_RD && redirect
    |=> flash_rd_o && !flash_addr_o[23]
        && flash_addr_o[22:15] == $past(vis_page_q))
    else $error("window address malformed");

  a_no_redirect: assert property ( // see RULE4
    take && op_i == PSAM_OP_DATA_RD && !(ea_i[15] && vis_en_q)
    |=> done_o && ram_path_o && !flash_rd_o)
    else $error("data read redirected without cause");

  a_fetch_align: assert property ( // see RULE20
    take && op_i == PSAM_OP_FETCH
    |=> !flash_addr_o[23] && !flash_addr_o[0]
        && flash_addr_o[22:1] == $past(pc_i))
    else $error("fetch address malformed");

  a_hi_phantom: assert property ( // see RULE11
    done_o && op_q == PSAM_OP_TBL_RD_HI |-> rdata_o[15:8] == 8'h00)
    else $error("phantom byte not zero");

  a_cfg_no_write: assert property ( // see RULE13
    take && is_wr && cfg_hit |=> !latch_we_o ##2 cfg_wr_err_q)
    else $error("config write reached the latches");

  a_move_stretch: assert property ( // see RULE17
    take && op_i == PSAM_OP_DATA_RD && redirect && !in_rpt_i
    && cls_i != PSAM_CLS_OTHER |=> !done_o [*3] ##1 done_o)
    else $error("window move not one extra cycle");

  a_other_stretch: assert property ( // see RULE17
    take && op_i == PSAM_OP_DATA_RD && redirect && !in_rpt_i
    && cls_i == PSAM_CLS_OTHER |-> ##5 done_o)
    else $error("window other not two extra cycles");

  a_rpt_mid: assert property ( // see RULE18
    take && op_i == PSAM_OP_DATA_RD && redirect && in_rpt_i
    && !rpt_edge_i |-> ##3 done_o)
    else $error("mid repeat window read stretched");

  a_latch_load: assert property ( // see RULE19
    take && is_wr && !cfg_hit |=> latch_we_o && !flash_rd_o)
    else $error("table write did not load latch");

  c_window_read: cover property (
    take && op_i == PSAM_OP_DATA_RD && redirect);
  c_tbl_high_byte: cover property (
    take && op_i == PSAM_OP_TBL_RD_HI && byte_mode_i && ea_i[0]);
  c_cfg_refused: cover property (take && is_wr && cfg_hit);
  c_apb_error: cover property (pslverr_o);

endmodule // psam_top

`default_nettype wire

// *** bench/psam_flash_model.sv ***
/*
  program flash model for the access mapper bench.
  assumes the mapper reads with a one-cycle strobe, one clock.
*/
`timescale 1ns/1ps
`default_nettype none

module psam_flash_model (
  input wire logic clk_i,
  input wire logic rd_i,
  input wire logic [23:0] addr_i,
  output var logic [23:0] rdata_o
);
  // contents follow the word address so each lane differs
  function automatic logic [23:0] word(input logic [23:0] a);
    return {a[23:16] ^ a[8:1], a[16:1]};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // word valid only in the cycle after the strobe; toggles otherwise
  // so a late sample never matches by luck
  initial rdata_o = 24'h5A_5A5A;
  always @(posedge clk_i) begin
    if (rd_i) begin
      rdata_o <= word(addr_i);
    end else begin
      rdata_o <= ~rdata_o;
    end
  end
endmodule // psam_flash_model
`default_nettype wire

// *** bench/psam_bench.sv ***
/*
  self-checking bench of the program space access mapper.
  assumes psam_top, its package and constants, and the flash model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psam_consts.svh"

module psam_bench import psam_pkg::*;;
  // one row: request fields, page, enable, expected latency
  typedef struct {
    psam_op_t op; logic bm; logic [15:0] ea; logic [21:0] pc;
    psam_cls_t cls; logic rpt; logic edg; logic en; logic [7:0] pg;
    int lat;
  } psam_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = '0, penable_i = '0, pwrite_i = '0;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, rd;
  logic pready_o, pslverr_o, er;
  logic req_i = '0, byte_mode_i = '0, in_rpt_i = '0, rpt_edge_i = '0;
  psam_op_t op_i = PSAM_OP_FETCH;
  psam_cls_t cls_i = PSAM_CLS_MOVE;
  logic [15:0] ea_i = '0, wdata_i = '0, rdata_o, latch_data_o;
  logic [21:0] pc_i = '0;
  logic ready_o, done_o, ram_path_o, refused_o, flash_rd_o;
  logic latch_we_o, latch_high_o, latch_byte_o;
  logic [23:0] flash_addr_o, flash_rdata_i, seen_addr, latch_addr, a;
  int err_total = 0, cmp_count = 0, lat, latch_cnt = 0, k;
  psam_row_t rows[16] = '{
    '{PSAM_OP_TBL_RD_LO, 0, 16'h1235, '0, PSAM_CLS_MOVE, 0, 0, 0, 8'h12, 3},
    '{PSAM_OP_TBL_RD_LO, 1, 16'h1235, '0, PSAM_CLS_MOVE, 0, 0, 0, 8'h12, 3},
    '{PSAM_OP_TBL_RD_LO, 1, 16'h1234, '0, PSAM_CLS_MOVE, 0, 0, 0, 8'h12, 3},
    '{PSAM_OP_TBL_RD_HI, 0, 16'h0FFF, '0, PSAM_CLS_MOVE, 0, 0, 0, 8'h7F, 3},
    '{PSAM_OP_TBL_RD_HI, 1, 16'h0FFE, '0, PSAM_CLS_MOVE, 0, 0, 0, 8'h7F, 3},
    '{PSAM_OP_TBL_RD_HI, 1, 16'h0FFF, '0, PSAM_CLS_MOVE, 0, 0, 0, 8'h7F, 3},
    '{PSAM_OP_TBL_RD_LO, 0, 16'hABCD, '0, PSAM_CLS_MOVE, 0, 0, 0, 8'h81, 3},
    '{PSAM_OP_DATA_RD, 0, 16'h9ACF, '0, PSAM_CLS_MOVE, 0, 0, 1, 8'h5A, 4},
    '{PSAM_OP_DATA_RD, 0, 16'h9ACF, '0, PSAM_CLS_DMOVE, 0, 0, 1, 8'h5A, 4},
    '{PSAM_OP_DATA_RD, 0, 16'hFFFF, '0, PSAM_CLS_OTHER, 0, 0, 1, 8'hFF, 5},
    '{PSAM_OP_DATA_RD, 0, 16'h8001, '0, PSAM_CLS_MOVE, 1, 1, 1, 8'hA5, 5},
    '{PSAM_OP_DATA_RD, 0, 16'h8002, '0, PSAM_CLS_OTHER, 1, 0, 1, 8'hA5, 3},
    '{PSAM_OP_DATA_RD, 0, 16'h7FFE, '0, PSAM_CLS_MOVE, 0, 0, 1, 8'h5A, 1},
    '{PSAM_OP_DATA_RD, 0, 16'h8000, '0, PSAM_CLS_MOVE, 0, 0, 0, 8'h5A, 1},
    '{PSAM_OP_FETCH, 0, 16'h0000, 22'h3F_FFFF, PSAM_CLS_MOVE, 0, 0, 0, 0, 3},
    '{PSAM_OP_FETCH, 0, 16'h0000, 22'h00_0001, PSAM_CLS_MOVE, 0, 0, 0, 0, 3}};

  always #20 clk_i = ~clk_i;

  // top config page left unimplemented so the zero-read path is reached
  psam_top #(.CFG_IMPL_HI(24'hFE_FFFF)) psam_top_i (.clk_i, .rst_i,
    .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .req_i, .op_i,
    .byte_mode_i, .ea_i, .wdata_i, .pc_i, .cls_i, .in_rpt_i, .rpt_edge_i,
    .ready_o, .done_o, .rdata_o, .ram_path_o, .refused_o, .flash_addr_o,
    .flash_rd_o, .flash_rdata_i, .latch_we_o, .latch_high_o,
    .latch_byte_o, .latch_data_o);
  psam_flash_model psam_flash_model_i (.clk_i, .rd_i(flash_rd_o),
    .addr_i(flash_addr_o), .rdata_o(flash_rdata_i));

  ////////////////////////////////////////////////////////////////////
  // monitor: last flash read address and latch loads
  always @(posedge clk_i) begin
    if (flash_rd_o === 1'b1) seen_addr <= flash_addr_o;
    if (latch_we_o === 1'b1) begin
      latch_cnt <= latch_cnt + 1;
      latch_addr <= flash_addr_o;
    end
  end

  task automatic chk(input string what, input logic [31:0] s, x);
    cmp_count++;
    if (s !== x) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, x, s);
    end
  endtask

  // apb master; starts on an edge so psel is never set twice
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    chk("apb ready", {31'h0, pready_o}, 32'h1);
  endtask

  // core request; lat is the cycle in which done_o shows
  task automatic core(input psam_row_t r);
    int n;
    n = 0;
    @(posedge clk_i);
    while (ready_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    req_i <= 1'b1;
    op_i <= r.op;
    byte_mode_i <= r.bm;
    ea_i <= r.ea;
    pc_i <= r.pc;
    cls_i <= r.cls;
    in_rpt_i <= r.rpt;
    rpt_edge_i <= r.edg;
    @(posedge clk_i);
    req_i <= 1'b0;
    lat = 1;
    #1;
    while (done_o !== 1'b1 && lat < 40) begin
      @(posedge clk_i);
      #1;
      lat++;
    end
  endtask

  function automatic logic [23:0] exp_addr(input psam_row_t r);
    case (r.op)
      PSAM_OP_FETCH: return {1'b0, r.pc, 1'b0};
      PSAM_OP_DATA_RD: return {1'b0, r.pg, r.ea[14:0]};
      default: return {r.pg, r.ea};
    endcase
  endfunction

  function automatic logic [15:0] exp_data(input psam_row_t r,
                                           input logic [23:0] ad);
    logic [23:0] w;
    w = {ad[23:16] ^ ad[8:1], ad[16:1]};
    case (r.op)
      PSAM_OP_TBL_RD_LO:
        return !r.bm ? w[15:0] : {8'h00, r.ea[0] ? w[15:8] : w[7:0]};
      PSAM_OP_TBL_RD_HI:
        return (r.bm && r.ea[0]) ? 16'h0000 : {8'h00, w[23:16]};
      default: return w[15:0];
    endcase
  endfunction

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    final_report();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // table rows, window rows, ram rows, fetch rows
    for (k = 0; k < 16; k++) begin
      apb(1'b1, `PSAM_OFF_TBL_PAGE, {24'h0, rows[k].pg});
      apb(1'b1, `PSAM_OFF_VIS_PAGE, {24'h0, rows[k].pg});
      apb(1'b1, `PSAM_OFF_CPU_CTRL, {29'h0, rows[k].en, 2'h0});
      seen_addr = 24'hEE_EEEE;
      core(rows[k]);
      a = exp_addr(rows[k]);
      chk("latency", lat, rows[k].lat);
      if (rows[k].lat == 1) begin
        chk("ram path", {31'h0, ram_path_o}, 32'h1);
        chk("no flash", {8'h0, seen_addr}, 32'hEE_EEEE);
      end else begin
        chk("flash addr", {8'h0, seen_addr}, {8'h0, a});
        if (rows[k].op != PSAM_OP_FETCH)
          chk("data", {16'h0, rdata_o}, exp_data(rows[k], a));
      end
      $display("row %0d done", k);
    end
    // unimplemented configuration read answers zero, flash untouched
    apb(1'b1, `PSAM_OFF_TBL_PAGE, 32'h0000_00FF);
    seen_addr = 24'hEE_EEEE;
    core('{PSAM_OP_TBL_RD_LO, 0, 16'h0010, '0, PSAM_CLS_MOVE, 0, 0, 0, 0, 3});
    chk("cfg rd lat", lat, 3);
    chk("cfg rd zero", {16'h0, rdata_o}, 32'h0);
    chk("cfg rd refused", {31'h0, refused_o}, 32'h1);
    chk("cfg rd flash", {8'h0, seen_addr}, 32'hEE_EEEE);
    apb(1'b0, `PSAM_OFF_STATUS, '0);
    chk("cfg rd status", {31'h0, rd[`PSAM_STAT_CFGRD_BIT]}, 32'h1);
    $display("config read done");
    // user table write loads a latch only, odd byte address
    apb(1'b1, `PSAM_OFF_TBL_PAGE, 32'h0000_0003);
    wdata_i <= 16'hBEEF;
    k = latch_cnt;
    seen_addr = 24'hEE_EEEE;
    core('{PSAM_OP_TBL_WR_LO, 0, 16'h2223, '0, PSAM_CLS_MOVE, 0, 0, 0, 3, 3});
    chk("latch count", latch_cnt, k + 1);
    chk("latch data", {16'h0, latch_data_o}, 32'h0000_BEEF);
    chk("latch high", {31'h0, latch_high_o}, 32'h0);
    chk("latch byte", {31'h0, latch_byte_o}, 32'h0);
    chk("latch addr", {8'h0, latch_addr}, 32'h0003_2223);
    chk("array read", {8'h0, seen_addr}, 32'hEE_EEEE);
    chk("write latency", lat, 3);
    $display("table write done");
    // configuration write is refused
    apb(1'b1, `PSAM_OFF_TBL_PAGE, 32'h0000_0080);
    k = latch_cnt;
    core('{PSAM_OP_TBL_WR_HI, 0, 16'h0004, '0, PSAM_CLS_MOVE, 0, 0, 0, 0, 3});
    chk("cfg latch", latch_cnt, k);
    chk("cfg refused", {31'h0, refused_o}, 32'h1);
    apb(1'b0, `PSAM_OFF_STATUS, '0);
    chk("cfg status", {31'h0, rd[`PSAM_STAT_CFGWR_BIT]}, 32'h1);
    $display("config write done");
    // unmapped register
    apb(1'b0, 12'h010, '0);
    chk("unmapped err", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0000_0000);
    $display("unmapped done");
    // second reset clears the pages and the enable
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    chk("ready in reset", {31'h0, ready_o}, 32'h0);
    rst_i <= 1'b0;
    apb(1'b0, `PSAM_OFF_TBL_PAGE, '0);
    chk("table page", rd, 32'h0000_0000);
    apb(1'b0, `PSAM_OFF_VIS_PAGE, '0);
    chk("window page", rd, 32'h0000_0000);
    apb(1'b0, `PSAM_OFF_CPU_CTRL, '0);
    chk("control", rd, 32'h0000_0000);
    apb(1'b0, `PSAM_OFF_STATUS, '0);
    chk("status", rd, 32'h0000_0000);
    $display("reset done");
    final_report();
  end
endmodule // psam_bench
`default_nettype wire
